//--- inc/seg_decoder_pkg.sv
// Purpose: Shared constants and types for the four-digit segment decoder and its source.
// Assumes: 40 MHz sys_clk; all times converted to clock cycles here.
// Notes: The oscillator is modelled as a clock-enable divider off sys_clk.
package seg_decoder_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned NUM_DIGITS = 4;
    localparam int unsigned SEG_W = 7;

    // Internal oscillator near 16 kHz, backplane is oscillator divided by 128
    // One divider tick per full oscillator period, not per half period
    localparam int unsigned OSC_HZ = 16_000;
    localparam int unsigned OSC_CYCLES = CLK_HZ / OSC_HZ;
    localparam int unsigned BP_DIVIDE = 128;
    localparam int unsigned BP_HZ = 125;

    // Least low time on the oscillator input that counts as a disable
    localparam int unsigned OSC_LOW_MIN_NS = 1000;
    localparam int unsigned OSC_LOW_CYCLES = (OSC_LOW_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Least width of a digit-select strobe from the source
    localparam int unsigned SELECT_PULSE_MIN_NS = 1000;
    localparam int unsigned SELECT_PULSE_MIN_CYCLES =
        (SELECT_PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Counter widths
    localparam int unsigned OSC_CNT_W = 12;
    localparam int unsigned BP_CNT_W = 7;
    localparam int unsigned LOW_CNT_W = 6;
    localparam int unsigned STB_CNT_W = 6;

    localparam logic [OSC_CNT_W-1:0] OSC_CNT_LAST = OSC_CNT_W'(OSC_CYCLES - 1);
    localparam logic [LOW_CNT_W-1:0] LOW_CNT_LAST = LOW_CNT_W'(OSC_LOW_CYCLES);
    localparam logic [STB_CNT_W-1:0] STB_CNT_LAST = STB_CNT_W'(SELECT_PULSE_MIN_CYCLES - 1);

    // Reset values
    localparam logic [SEG_W-1:0] SEG_RESET = 7'h00;
    localparam logic BP_OE_RESET = 1'b1;

    // Segment pattern order: bit 0 = a ... bit 6 = g, high means lit
    typedef logic [SEG_W-1:0] seg_t;

    // Source sequencer states
    typedef enum logic [2:0] {
        SRC_IDLE = 3'b001,
        SRC_STROBE = 3'b010,
        SRC_GAP = 3'b100
    } src_state_t;

endpackage

//--- inc/seg_link_if.sv
// Purpose: Pins between the digit source and the segment decoder.
// Assumes: One clock domain; backplane pin not carried here, the bench resolves it from the enable.
// Notes: A second master may drive ext_bp when the decoder is a slave.
`timescale 1ns/10ps
`default_nettype none
interface seg_link_if;
    logic code_in_weight1;
    logic code_in_weight2;
    logic code_in_weight4;
    logic code_in_weight8;
    logic digit_select_lsd;
    logic digit_select_second;
    logic digit_select_third;
    logic digit_select_msd;

    modport device (
        input code_in_weight1, code_in_weight2, code_in_weight4, code_in_weight8,
        input digit_select_lsd, digit_select_second, digit_select_third, digit_select_msd
    );
    modport source (
        output code_in_weight1, code_in_weight2, code_in_weight4, code_in_weight8,
        output digit_select_lsd, digit_select_second, digit_select_third, digit_select_msd
    );
endinterface
`default_nettype wire

//--- design/seg_source.sv
// Purpose: Multiplexed source that writes one 4-bit code into every digit set in the mask at once.
// Assumes: User request is a one-cycle pulse with digit mask and code.
// Notes: Strobe held for the least select width, then one gap cycle.
`timescale 1ns/10ps
`default_nettype none
module seg_source (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic write_req,
    input wire logic [3:0] write_code,
    input wire logic [3:0] write_digits,
    output logic busy,
    seg_link_if.source link
);
    import seg_decoder_pkg::*;

    src_state_t state_q;
    logic [STB_CNT_W-1:0] cnt_q;
    logic [3:0] code_q;
    logic [3:0] sel_q;

    // Sequencer: idle, strobe for the least width, one clear gap
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= SRC_IDLE;
            cnt_q <= '0;
            busy <= 1'b0;
        end else begin
            unique case (state_q)
                SRC_IDLE: begin
                    cnt_q <= '0;
                    if (write_req && write_digits != 4'h0) begin
                        state_q <= SRC_STROBE;
                        busy <= 1'b1;
                    end
                end
                SRC_STROBE: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == STB_CNT_LAST) begin
                        state_q <= SRC_GAP;
                    end
                end
                SRC_GAP: begin
                    state_q <= SRC_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // Code and select stay stable for the whole strobe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            code_q <= 4'h0;
            sel_q <= 4'h0;
        end else if (state_q == SRC_IDLE && write_req && write_digits != 4'h0) begin
            code_q <= write_code;
            sel_q <= write_digits;
        end else if (state_q == SRC_STROBE && cnt_q == STB_CNT_LAST) begin
            sel_q <= 4'h0;
        end
    end

    // Bit 0 is the ones weight
    assign link.code_in_weight1 = code_q[0];
    assign link.code_in_weight2 = code_q[1];
    assign link.code_in_weight4 = code_q[2];
    assign link.code_in_weight8 = code_q[3];
    assign link.digit_select_lsd = sel_q[0];
    assign link.digit_select_second = sel_q[1];
    assign link.digit_select_third = sel_q[2];
    assign link.digit_select_msd = sel_q[3];

endmodule
`default_nettype wire

//--- design/seg_decoder.sv
// Purpose: Four-digit seven-segment LCD decoder with backplane master/slave drive.
// Assumes: Pins synchronous to sys_clk; oscillator emulated by dividing sys_clk.
// Notes: Segment outputs toggle with the backplane; lit segments run inverted.
// Port notes
// sys_clk, reset_n: one clock domain, asynchronous active-low reset
// link: four code bits and four digit selects, all level inputs
// osc_input: level for the disable filter only, divider runs free; a long low makes a slave
// backplane_pin_in: resolved backplane wire, read only in slave mode
// backplane_pin_out, backplane_pin_oe: own wave and its drive enable
// seg_out: digit d owns bits d*7+6 down to d*7, bit 0 is segment a
// slave_mode: high while the oscillator input is held low
//
// Timing
// A select sampled high loads that digit latch at the same edge.
// Master mode: seg_out shows the new pattern one edge later.
// Slave mode: the pin is registered first, so seg_out trails it by two.
// In master mode backplane and segments leave one register stage together, so no
// skew between them can put a DC term across the glass.
// A select shorter than 1 us still loads, since the latch takes the
// pattern at the first edge; the source keeps the full width anyway.
// Reset clears every latch, so all digits come up blank.
//
// Limitations
// The RC oscillator is a counter on sys_clk; its rate cannot be trimmed.
// An external clock on osc_input is not used as a clock; it only counts
// as a level for the disable filter.
// The slave path follows the pin level only; edge rate is up to whoever
// drives the shared backplane wire.
// The master wave starts low after reset and first rises after 64 ticks.
// More than four devices on one backplane want an external source.
`timescale 1ns/10ps
`default_nettype none
module seg_decoder (
    input wire logic sys_clk,
    input wire logic reset_n,
    seg_link_if.device link,
    input wire logic osc_input,
    input wire logic backplane_pin_in,
    output logic backplane_pin_out,
    output logic backplane_pin_oe,
    output logic [seg_decoder_pkg::NUM_DIGITS*seg_decoder_pkg::SEG_W-1:0] seg_out,
    output logic slave_mode
);
    import seg_decoder_pkg::*;

    // Link pins gathered into a code and a select mask
    logic [3:0] code;
    logic [3:0] sel;

    // Decode result and the four digit latches
    seg_t pattern;
    seg_t latch_q [NUM_DIGITS];

    // Oscillator, backplane divider and disable filter state
    logic [OSC_CNT_W-1:0] osc_cnt_q;
    logic osc_tick;
    logic [BP_CNT_W-1:0] bp_cnt_q;
    logic [LOW_CNT_W-1:0] low_cnt_q;

    // Registered copy of the external backplane and the wave in use
    logic bp_in_q;
    logic bp_wave;

    assign code = {link.code_in_weight8, link.code_in_weight4,
                   link.code_in_weight2, link.code_in_weight1};
    assign sel = {link.digit_select_msd, link.digit_select_third,
                  link.digit_select_second, link.digit_select_lsd};

    // Decode table, bit 0 = segment a up to bit 6 = segment g
    //      a
    //    f   b
    //      g
    //    e   c
    //      d
    // Fixed in hardware, so every code has one defined pattern
    always_comb begin
        unique case (code)
            4'h0: pattern = 7'h3F;
            4'h1: pattern = 7'h06;
            4'h2: pattern = 7'h5B;
            4'h3: pattern = 7'h4F;
            4'h4: pattern = 7'h66;
            4'h5: pattern = 7'h6D;
            4'h6: pattern = 7'h7D;
            4'h7: pattern = 7'h07;
            4'h8: pattern = 7'h7F;
            4'h9: pattern = 7'h6F;
            4'hA: pattern = 7'h40; // Dash
            4'hB: pattern = 7'h79; // E
            4'hC: pattern = 7'h76; // H
            4'hD: pattern = 7'h38; // L
            4'hE: pattern = 7'h73; // P
            4'hF: pattern = 7'h00; // Blank
        endcase
    end

    // Digit latches, loaded at each edge a select is high
    // Several selects load the same pattern; an idle select holds
    for (genvar d = 0; d < NUM_DIGITS; d++) begin : g_digit
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                latch_q[d] <= SEG_RESET;
            end else if (sel[d]) begin
                latch_q[d] <= pattern;
            end
        end
    end

    // Emulated RC oscillator: one tick per period at about 16 kHz
    // Ticking on half periods would double the backplane rate
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_cnt_q <= '0;
        end else if (osc_cnt_q == OSC_CNT_LAST) begin
            osc_cnt_q <= '0;
        end else begin
            osc_cnt_q <= osc_cnt_q + 1'b1;
        end
    end
    assign osc_tick = (osc_cnt_q == OSC_CNT_LAST);

    // Divider by 128 of the oscillator; MSB is the backplane wave
    // The MSB spends 64 ticks high and 64 low, a 50 percent wave
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bp_cnt_q <= '0;
        end else if (osc_tick) begin
            bp_cnt_q <= bp_cnt_q + 1'b1;
        end
    end

    // Disable detect: only a low lasting more than 1 us enters slave mode
    // Saturating counter; any high sample clears it and the mode
    // Pulses of up to 40 cycles never reach the threshold
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt_q <= '0;
            slave_mode <= 1'b0;
        end else if (osc_input) begin
            low_cnt_q <= '0;
            slave_mode <= 1'b0;
        end else if (low_cnt_q == LOW_CNT_LAST) begin
            slave_mode <= 1'b1;
        end else begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    // Register the external backplane so outputs stay flop-driven
    // The wire may come from another device, so take it on an edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bp_in_q <= 1'b0;
        end else begin
            bp_in_q <= backplane_pin_in;
        end
    end

    // Master drives own wave; slave follows the registered pin
    // Master wave is used unregistered here, matching the pin stage
    assign bp_wave = slave_mode ? bp_in_q : bp_cnt_q[BP_CNT_W-1];

    // Pin drive: own wave always, enable dropped in slave mode
    // The enable trails slave_mode by one edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            backplane_pin_out <= 1'b0;
            backplane_pin_oe <= BP_OE_RESET;
        end else begin
            backplane_pin_out <= bp_cnt_q[BP_CNT_W-1];
            backplane_pin_oe <= ~slave_mode;
        end
    end

    // Segments XOR backplane; same register stage as the backplane pin
    // XOR gives in-phase drive for off, antiphase for on
    // A blank digit still toggles with the backplane, so no DC term
    for (genvar d = 0; d < NUM_DIGITS; d++) begin : g_seg
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                seg_out[d*SEG_W +: SEG_W] <= SEG_RESET;
            end else begin
                seg_out[d*SEG_W +: SEG_W] <= latch_q[d] ^ {SEG_W{bp_wave}};
            end
        end
    end

endmodule
`default_nettype wire

//--- bench/seg_link_props.sv
// Purpose: Timing checks on the source-to-decoder link and backplane pins.
// Assumes: One sys_clk domain, reset_n async active low.
// Notes: Master backplane toggles too slowly to be seen in a short run.
`timescale 1ns/10ps
`default_nettype none
module seg_link_props
    import seg_decoder_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic digit_select_lsd,
    input wire logic digit_select_second,
    input wire logic digit_select_third,
    input wire logic digit_select_msd,
    input wire logic osc_input,
    input wire logic backplane_pin_in,
    input wire logic backplane_pin_out,
    input wire logic backplane_pin_oe,
    input wire logic [NUM_DIGITS*SEG_W-1:0] seg_out,
    input wire logic slave_mode
);
    logic sel_any;
    int lo_n;
    int hi_n;
    int bp_n;
    assign sel_any = digit_select_lsd | digit_select_second |
                     digit_select_third | digit_select_msd;
    // Run lengths of low oscillator, high selects, steady backplane
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lo_n <= 0;
            hi_n <= 0;
            bp_n <= 0;
        end else begin
            lo_n <= osc_input ? 0 : lo_n + 1;
            hi_n <= sel_any ? hi_n + 1 : 0;
            bp_n <= $changed(backplane_pin_out) ? 0 : bp_n + 1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_oe_master: assert property (!$past(slave_mode) |-> backplane_pin_oe)
        else $error("backplane not driven in master mode");
    a_oe_slave: assert property ($past(slave_mode) |-> !backplane_pin_oe)
        else $error("backplane driven in slave mode");
    a_slave_entry: assert property (lo_n == 60 |-> slave_mode)
        else $error("long low oscillator input did not give slave mode");
    a_short_low: assert property ($rose(slave_mode) |-> lo_n >= 40)
        else $error("slave mode entered on a short low pulse");
    a_osc_high: assert property (osc_input [*3] |-> !slave_mode)
        else $error("slave mode kept while oscillator input high");
    a_bp_divide: assert property ($changed(backplane_pin_out) |->
        bp_n >= BP_DIVIDE / 2 * OSC_CYCLES - 2)
        else $error("backplane half period too short");
    a_sel_width: assert property ($fell(sel_any) |->
        hi_n >= SELECT_PULSE_MIN_CYCLES)
        else $error("digit select strobe too short");
    a_seg_hold: assert property ((!sel_any && $stable(backplane_pin_in)) [*6] |->
        $past(seg_out) == $past(seg_out, 2))
        else $error("segments changed without select or backplane edge");
    a_seg_invert: assert property ((!sel_any) [*4] ##1
        ($changed(backplane_pin_in) && slave_mode && !sel_any) |->
        ##[1:3] (seg_out == ~$past(seg_out)))
        else $error("segments did not follow the backplane edge");
    a_reset_vals: assert property ($rose(reset_n) |->
        seg_out == '0 && backplane_pin_oe && !slave_mode)
        else $error("wrong values out of reset");
endmodule
`default_nettype wire

//--- bench/tb_seg_decoder.sv
// Purpose: Self-checking bench joining the digit source to the segment decoder.
// Assumes: 40 MHz clock; external backplane driven only while decoder is a slave.
// Notes: Master backplane edge lies beyond the run, so phase is tested in slave mode.
`timescale 1ns/10ps
`default_nettype none
module tb_seg_decoder;
    import seg_decoder_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, write_req = 1'b0, osc_input = 1'b1, ext_bp = 1'b0;
    logic [3:0] write_code = 4'h0, write_digits = 4'h0;
    logic busy, backplane_pin_in, backplane_pin_out, backplane_pin_oe, slave_mode;
    logic [NUM_DIGITS*SEG_W-1:0] seg_out;
    seg_t exp_q [4] = '{default: '0};
    seg_t tbl [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                       7'h7f, 7'h6f, 7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};
    int bad_count = 0, n_compared = 0;
    seg_link_if link ();
    // Wire level: our own drive wins, else the external master
    assign backplane_pin_in = backplane_pin_oe ? backplane_pin_out : ext_bp;
    always #12.5 sys_clk = ~sys_clk;
    seg_source seg_source_i (.sys_clk, .reset_n, .write_req, .write_code, .write_digits,
        .busy, .link(link.source));
    seg_decoder seg_decoder_i (.sys_clk, .reset_n, .link(link.device), .osc_input,
        .backplane_pin_in, .backplane_pin_out, .backplane_pin_oe, .seg_out, .slave_mode);
    seg_link_props seg_link_props_i (.sys_clk, .reset_n,
        .digit_select_lsd(link.digit_select_lsd), .digit_select_second(link.digit_select_second),
        .digit_select_third(link.digit_select_third), .digit_select_msd(link.digit_select_msd),
        .osc_input, .backplane_pin_in, .backplane_pin_out, .backplane_pin_oe, .seg_out,
        .slave_mode);
    // Expected pins: latch pattern inverted when the backplane is high
    function automatic logic [NUM_DIGITS*SEG_W-1:0] exp_seg();
        logic [NUM_DIGITS*SEG_W-1:0] r;
        for (int d = 0; d < 4; d++) r[d*7 +: 7] = exp_q[d] ^ {7{backplane_pin_in}};
        return r;
    endfunction
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_seg();
        n_compared++;
        if (seg_out !== exp_seg()) begin
            bad_count++;
            $display("wrong value at %0t: seg_out %h expected %h", $time, seg_out, exp_seg());
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s is %b", $time, what, got);
        end
    endtask
    // One write through the source, then the pins are compared
    task automatic write(input logic [3:0] c, input logic [3:0] m);
        int n;
        @(posedge sys_clk);
        write_req <= 1'b1;
        write_code <= c;
        write_digits <= m;
        @(posedge sys_clk);
        write_req <= 1'b0;
        for (n = 0; n < 100; n++) begin
            @(posedge sys_clk);
            #1;
            if (!busy) break;
        end
        if (n == 100) begin
            bad_count++;
            $display("wrong value at %0t: busy stuck", $time);
            results();
        end
        for (int d = 0; d < 4; d++) if (m[d]) exp_q[d] = tbl[c];
        repeat (3) @(posedge sys_clk);
        #1;
        chk_seg();
    endtask
    initial begin
        void'($urandom(9512));
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk_seg();
        chk_bit(backplane_pin_oe, 1'b1, "oe");
        // Every code, walking across the digits
        for (int i = 0; i < 16; i++) write(4'(i), 4'(1 << (i % 4)));
        $display("test decode done");
        write(4'h8, 4'hf);
        write(4'h3, 4'h0);
        repeat (20) write(4'($urandom), 4'($urandom));
        $display("test masks done");
        // Low pulses up to two cycles short of the filter
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk) osc_input <= 1'b0;
            repeat (k == 3 ? 39 : 1 + $urandom % 20) @(posedge sys_clk);
            osc_input <= 1'b1;
            repeat (5) @(posedge sys_clk);
            #1;
            chk_bit(slave_mode, 1'b0, "slave_mode");
        end
        $display("test filter done");
        @(posedge sys_clk) osc_input <= 1'b0;
        repeat (50) @(posedge sys_clk);
        #1;
        chk_bit(slave_mode, 1'b1, "slave_mode");
        chk_bit(backplane_pin_oe, 1'b0, "oe");
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk) ext_bp <= ~ext_bp;
            repeat (4) @(posedge sys_clk);
            #1;
            chk_seg();
        end
        write(4'hb, 4'h6);
        @(posedge sys_clk) osc_input <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        chk_bit(slave_mode, 1'b0, "slave_mode");
        chk_bit(backplane_pin_oe, 1'b1, "oe");
        chk_seg();
        $display("test slave done");
        results();
    end
endmodule
`default_nettype wire
